// ===== gcd_pkg.sv
// constants for the command decoder
// assumes a single mclk domain and 16-byte command and status images
package gcd_pkg;

  localparam int unsigned IMG_BYTES = 16;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned NUM_AXES  = 4;

  // command image byte indices
  localparam logic [ADDR_W-1:0] IDX_ACTION   = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_OPTIONS  = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_OPTIONS2 = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_POS_A    = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_SPD_A    = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_POS_B    = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_SPD_B    = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_POS_C    = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_SPD_C    = 4'ha;
  localparam logic [ADDR_W-1:0] IDX_POS_S    = 4'hc;
  localparam logic [ADDR_W-1:0] IDX_SPD_S    = 4'hd;
  localparam logic [ADDR_W-1:0] IDX_RSVD     = 4'hf;

  // status image byte indices
  localparam logic [ADDR_W-1:0] SIDX_STATUS  = 4'h0;
  localparam logic [ADDR_W-1:0] SIDX_OBJECT  = 4'h1;
  localparam logic [ADDR_W-1:0] SIDX_FAULT   = 4'h2;
  localparam logic [ADDR_W-1:0] SIDX_ECHO_A  = 4'h3;
  localparam logic [ADDR_W-1:0] SIDX_POS_A   = 4'h4;
  localparam logic [ADDR_W-1:0] SIDX_ECHO_B  = 4'h6;
  localparam logic [ADDR_W-1:0] SIDX_POS_B   = 4'h7;
  localparam logic [ADDR_W-1:0] SIDX_ECHO_C  = 4'h9;
  localparam logic [ADDR_W-1:0] SIDX_POS_C   = 4'ha;
  localparam logic [ADDR_W-1:0] SIDX_ECHO_S  = 4'hc;
  localparam logic [ADDR_W-1:0] SIDX_POS_S   = 4'hd;

  // action byte fields, bit 0 is the lsb
  localparam int unsigned BIT_ACT     = 0;
  localparam int unsigned BIT_MODE_LO = 1;
  localparam int unsigned BIT_MODE_HI = 2;
  localparam int unsigned BIT_GO      = 3;
  localparam int unsigned BIT_REL     = 4;
  // options byte fields
  localparam int unsigned BIT_AAC     = 1;
  localparam int unsigned BIT_ICF     = 2;
  localparam int unsigned BIT_ICS     = 3;

  // grasp mode codes as read from bits 2:1
  localparam logic [1:0] MODE_BASIC   = 2'h0;
  localparam logic [1:0] MODE_PINCH   = 2'h2;
  localparam logic [1:0] MODE_WIDE    = 2'h1;
  localparam logic [1:0] MODE_SCISSOR = 2'h3;

  // scissor axis set points per mode, plain defaults
  localparam logic [7:0] SCIS_POS_BASIC   = 8'h80;
  localparam logic [7:0] SCIS_POS_PINCH   = 8'hf0;
  localparam logic [7:0] SCIS_POS_WIDE    = 8'h10;
  localparam logic [7:0] SCIS_POS_SCISSOR = 8'h00;
  // reduced scissor range under independent control
  localparam logic [7:0] SCIS_IND_MIN     = 8'h20;
  localparam logic [7:0] SCIS_IND_MAX     = 8'he0;

  localparam logic [7:0] POS_OPEN   = 8'h00;
  localparam logic [7:0] POS_CLOSED = 8'hff;
  localparam logic [7:0] STEP_SLOW  = 8'h01;
  localparam logic [7:0] STEP_FAST  = 8'h04;

  // status byte fields
  localparam int unsigned SBIT_ACT     = 0;
  localparam int unsigned SBIT_MODE_LO = 1;
  localparam int unsigned SBIT_GO      = 3;
  localparam int unsigned SBIT_INIT_LO = 4;
  localparam int unsigned SBIT_BUSY    = 6;
  localparam int unsigned SBIT_RELDONE = 7;
  localparam logic [1:0]  INIT_IDLE    = 2'h0;
  localparam logic [1:0]  INIT_BUSY    = 2'h1;
  localparam logic [1:0]  INIT_DONE    = 2'h3;
  localparam logic [7:0]  FAULT_NONE   = 8'h00;
  localparam logic [7:0]  FAULT_RELEASE = 8'h0f;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_INIT,
    ST_READY,
    ST_MODE_OPEN,
    ST_MODE_SET,
    ST_RELEASE,
    ST_FAULT
  } gcd_state_e;

endpackage : gcd_pkg

// ===== gcd_axis_if.sv
// bundle between the decoder and one motion axis
// assumes both ends run on mclk
interface gcd_axis_if;
  logic [7:0] target;
  logic [7:0] step;
  logic       move;
  logic [7:0] pos;
  logic       at_tgt;

  modport ctrl (output target, output step, output move, input pos, input at_tgt);
  modport axis (input target, input step, input move, output pos, output at_tgt);
endinterface : gcd_axis_if

// ===== gcd_cmd_image.sv
// command image storage, 16 bytes written by the controller
// assumes single-cycle write strobes on mclk; readback is registered
module gcd_cmd_image
  import gcd_pkg::*;
(
  input  wire logic                            mclk,
  input  wire logic                            rstn,
  input  wire logic                            wr_en,
  input  wire logic [gcd_pkg::ADDR_W-1:0]      wr_addr,
  input  wire logic [7:0]                      wr_data,
  input  wire logic                            rd_en,
  input  wire logic [gcd_pkg::ADDR_W-1:0]      rd_addr,
  output logic      [7:0]                      rd_data,
  output logic      [gcd_pkg::IMG_BYTES-1:0][7:0] image
);

  // every bit is stored as written, spare bits included
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      image <= '0;
    else if (wr_en)
      image[wr_addr] <= wr_data;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= image[rd_addr];
  end

endmodule : gcd_cmd_image

// ===== gcd_axis.sv
// one motion axis: position steps toward its target while enabled
// assumes target and step are stable on mclk
module gcd_axis
  import gcd_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  gcd_axis_if.axis  bus
);

  logic [7:0] gap;

  assign bus.at_tgt = (bus.pos == bus.target);
  assign gap        = (bus.pos < bus.target) ? (bus.target - bus.pos) : (bus.pos - bus.target);

  // position survives a deactivation, like the mechanics would
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      bus.pos <= POS_OPEN;
    else if (bus.move && !bus.at_tgt)
    begin
      if (bus.pos < bus.target)
        bus.pos <= bus.pos + ((gap < bus.step) ? gap : bus.step);
      else
        bus.pos <= bus.pos - ((gap < bus.step) ? gap : bus.step);
    end
  end

endmodule : gcd_axis

// ===== gcd_top.sv
// gripper command decoder: command image, mode sequencer, status image
// assumes controller strobes are synchronous to mclk
////////////////////////////////////////////////////////////////////////////////
//
// Contract
// - 16-byte command and status images, byte 15 reserved
// - bit 0 is each byte's least significant bit
// - action bit 0 activates; zero holds reset
// - clearing activation resets gripper and fault
// - nothing acts unless activation stays set
// - bits 2:1 select basic, pinch, wide, scissor; the code decodes 1 as wide and 2 as pinch
// - mode change opens all fingers first
// - mode select ignored under independent scissor
// - go moves fingers, zero stops them
// - auto release slowly opens every axis
// - release done raises fault, blocks motion
// - release beats everything except activation
// - auto centering synchronizes fingers B and C
// - per-finger requests, except plain scissor mode
// - per-finger enable moves fingers immediately while go is set
// - independent scissor follows scissor target byte
// - independent scissor uses reduced range
// - byte 3 target, 00 open, ff closed
// - byte 3 drives all, or finger A
// - major fault needs reactivation to resume
module gcd_top
  import gcd_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic                          cmd_wr_en,
  input  wire logic [gcd_pkg::ADDR_W-1:0]    cmd_wr_addr,
  input  wire logic [7:0]                    cmd_wr_data,
  input  wire logic                          cmd_rd_en,
  input  wire logic [gcd_pkg::ADDR_W-1:0]    cmd_rd_addr,
  output logic      [7:0]                    cmd_rd_data,
  input  wire logic                          sts_rd_en,
  input  wire logic [gcd_pkg::ADDR_W-1:0]    sts_rd_addr,
  output logic      [7:0]                    sts_rd_data,
  output logic      [gcd_pkg::NUM_AXES-1:0][7:0] axis_pos,
  output logic      [1:0]                    active_mode,
  output logic                               init_done,
  output logic                               motion_busy,
  output logic                               fault_major
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [IMG_BYTES-1:0][7:0] img;
  logic                      act;
  logic [1:0]                mode_sel;
  logic                      go;
  logic                      rel;
  logic                      aac;
  logic                      icf;
  logic                      ics;
  logic                      indiv;
  logic [7:0]                t_a;
  logic [7:0]                t_b;
  logic [7:0]                t_c;
  logic [7:0]                t_s;
  logic [7:0]                s_a;
  logic [7:0]                s_b;
  logic [7:0]                s_c;
  logic [7:0]                s_s;
  logic [NUM_AXES-1:0][7:0]  tgt_v;
  logic [NUM_AXES-1:0][7:0]  step_v;
  logic                      move_v;
  logic [NUM_AXES-1:0]       at_v;
  logic                      all_at;
  logic [7:0]                status_byte;
  logic [7:0]                sts_d;

  gcd_state_e                state_q;
  gcd_state_e                state_d;
  logic [1:0]                mode_q;
  logic                      fault_q;
  logic                      init_done_q;
  logic                      busy_q;

  gcd_axis_if                ax_if [NUM_AXES] ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // speed to step; slowest step stays above zero
  function automatic logic [7:0] step_of(input logic [7:0] speed);
    step_of = {6'h00, speed[7:6]} + STEP_SLOW;
  endfunction : step_of

  // independent scissor clamp
  function automatic logic [7:0] clamp_scis(input logic [7:0] p);
    if (p < SCIS_IND_MIN)
      clamp_scis = SCIS_IND_MIN;
    else if (p > SCIS_IND_MAX)
      clamp_scis = SCIS_IND_MAX;
    else
      clamp_scis = p;
  endfunction : clamp_scis

  // mode code to scissor set point
  function automatic logic [7:0] mode_pos(input logic [1:0] m);
    case (m)
      MODE_BASIC:   mode_pos = SCIS_POS_BASIC;
      MODE_PINCH:   mode_pos = SCIS_POS_PINCH;
      MODE_WIDE:    mode_pos = SCIS_POS_WIDE;
      MODE_SCISSOR: mode_pos = SCIS_POS_SCISSOR;
      default:      mode_pos = SCIS_POS_BASIC;
    endcase
  endfunction : mode_pos

  function automatic logic is_running(input gcd_state_e s);
    is_running = (s == ST_INIT) || (s == ST_READY) || (s == ST_MODE_OPEN) ||
                 (s == ST_MODE_SET);
  endfunction : is_running

  ////////////////////////////////////////////////////////////////////////////
  // command image

  // shared byte map, byte 15 held but unused
  gcd_cmd_image u_image (
    .mclk    (mclk),
    .rstn    (rstn),
    .wr_en   (cmd_wr_en),
    .wr_addr (cmd_wr_addr),
    .wr_data (cmd_wr_data),
    .rd_en   (cmd_rd_en),
    .rd_addr (cmd_rd_addr),
    .rd_data (cmd_rd_data),
    .image   (img)
  );

  assign act      = img[IDX_ACTION][BIT_ACT];
  assign mode_sel = img[IDX_ACTION][BIT_MODE_HI:BIT_MODE_LO];
  assign go       = img[IDX_ACTION][BIT_GO];
  assign rel      = img[IDX_ACTION][BIT_REL];
  assign aac      = img[IDX_OPTIONS][BIT_AAC];
  assign icf      = img[IDX_OPTIONS][BIT_ICF];
  assign ics      = img[IDX_OPTIONS][BIT_ICS];
  // spare bits and byte 2 feed no logic

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  assign indiv = icf && !((mode_q == MODE_SCISSOR) && !ics);

  // byte 3 is the shared target
  // shared target, or finger A only
  assign t_a = img[IDX_POS_A];
  assign s_a = img[IDX_SPD_A];
  assign t_b = indiv ? img[IDX_POS_B] : t_a;
  assign s_b = indiv ? img[IDX_SPD_B] : s_a;
  assign t_c = !indiv ? t_a : (aac ? t_b : img[IDX_POS_C]);
  assign s_c = !indiv ? s_a : (aac ? s_b : img[IDX_SPD_C]);
  // independent scissor takes its own target
  assign t_s = ics ? clamp_scis(img[IDX_POS_S]) : mode_pos(mode_q);
  assign s_s = ics ? img[IDX_SPD_S] : s_a;

  ////////////////////////////////////////////////////////////////////////////
  // axes

  always_comb
  begin
    tgt_v  = '0;
    step_v = '0;
    move_v = 1'b0;
    case (state_q)
      ST_INIT, ST_MODE_OPEN:
      begin
        // every axis opens before the new mode
        for (int i = 0; i < NUM_AXES; i++)
        begin
          tgt_v[i]  = POS_OPEN;
          step_v[i] = STEP_FAST;
        end
        move_v = 1'b1;
      end
      ST_MODE_SET:
      begin
        // fingers stay open while the scissor reaches the mode point
        for (int i = 0; i < NUM_AXES - 1; i++)
        begin
          tgt_v[i]  = POS_OPEN;
          step_v[i] = STEP_FAST;
        end
        tgt_v[NUM_AXES-1]  = mode_pos(mode_q);
        step_v[NUM_AXES-1] = STEP_FAST;
        move_v = 1'b1;
      end
      ST_READY:
      begin
        tgt_v  = {t_s, t_c, t_b, t_a};
        step_v = {step_of(s_s), step_of(s_c), step_of(s_b), step_of(s_a)};
        // per-finger targets apply at once under go
        move_v = go;
      end
      ST_RELEASE:
      begin
        for (int i = 0; i < NUM_AXES; i++)
        begin
          tgt_v[i]  = POS_OPEN;
          step_v[i] = STEP_SLOW;
        end
        move_v = 1'b1;
      end
      default:
      begin
        // reset and fault hold the axes still
        move_v = 1'b0;
      end
    endcase
  end

  generate
    for (genvar g = 0; g < NUM_AXES; g++)
    begin : g_axis
      assign ax_if[g].target = tgt_v[g];
      assign ax_if[g].step   = step_v[g];
      assign ax_if[g].move   = move_v;
      assign at_v[g]         = ax_if[g].at_tgt;
      assign axis_pos[g]     = ax_if[g].pos;

      gcd_axis u_axis (
        .mclk (mclk),
        .rstn (rstn),
        .bus  (ax_if[g].axis)
      );
    end
  endgenerate

  assign all_at = &at_v;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb
  begin
    state_d = state_q;
    if (!act)
      state_d = ST_RESET;
    else if (is_running(state_q) && rel)
      state_d = ST_RELEASE;
    else
    begin
      case (state_q)
        ST_RESET:
          state_d = ST_INIT;
        ST_INIT:
          if (all_at)
            state_d = ST_MODE_SET;
        ST_READY:
          // mode select ignored under independent scissor
          if (!ics && (mode_sel != mode_q))
            state_d = ST_MODE_OPEN;
        ST_MODE_OPEN:
          if (all_at)
            state_d = ST_MODE_SET;
        ST_MODE_SET:
          if (all_at)
            state_d = ST_READY;
        ST_RELEASE:
          if (all_at)
            state_d = ST_FAULT;
        ST_FAULT:
          // only a deactivation leaves the fault
          state_d = ST_FAULT;
        default:
          state_d = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_q <= ST_RESET;
    else
      state_q <= state_d;
  end

  // mode latched once the fingers are fully open
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mode_q <= MODE_BASIC;
    else if (!act)
      mode_q <= MODE_BASIC;
    else if (state_q == ST_MODE_OPEN && all_at && !rel)
      mode_q <= mode_sel;
    // init keeps the basic mode under independent scissor
    else if (state_q == ST_INIT && all_at && !rel && !ics)
      mode_q <= mode_sel;
  end

  // deactivation clears the fault even against a same-cycle set
  // fault raised when the release finishes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      fault_q <= 1'b0;
    else if (!act)
      fault_q <= 1'b0;
    else if (state_q == ST_RELEASE && all_at)
      fault_q <= 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      init_done_q <= 1'b0;
    else if (!act)
      init_done_q <= 1'b0;
    else if (state_q == ST_MODE_SET && all_at)
      init_done_q <= 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      busy_q <= 1'b0;
    else
      busy_q <= move_v && !all_at;
  end

  assign active_mode = mode_q;
  assign init_done   = init_done_q;
  assign motion_busy = busy_q;
  assign fault_major = fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // status image

  always_comb
  begin
    status_byte                    = 8'h00;
    status_byte[SBIT_ACT]          = act;
    status_byte[SBIT_MODE_LO +: 2] = mode_q;
    status_byte[SBIT_GO]           = go;
    status_byte[SBIT_INIT_LO +: 2] = !act ? INIT_IDLE :
                                     (init_done_q ? INIT_DONE : INIT_BUSY);
    status_byte[SBIT_BUSY]         = busy_q;
    status_byte[SBIT_RELDONE]      = fault_q;
  end

  // status bytes share the command indices; reserved reads zero
  always_comb
  begin
    sts_d = 8'h00;
    case (sts_rd_addr)
      SIDX_STATUS: sts_d = status_byte;
      SIDX_OBJECT: sts_d = 8'h00;
      SIDX_FAULT:  sts_d = fault_q ? FAULT_RELEASE : FAULT_NONE;
      SIDX_ECHO_A: sts_d = t_a;
      SIDX_POS_A:  sts_d = axis_pos[0];
      SIDX_ECHO_B: sts_d = t_b;
      SIDX_POS_B:  sts_d = axis_pos[1];
      SIDX_ECHO_C: sts_d = t_c;
      SIDX_POS_C:  sts_d = axis_pos[2];
      SIDX_ECHO_S: sts_d = t_s;
      SIDX_POS_S:  sts_d = axis_pos[3];
      default:     sts_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sts_rd_data <= 8'h00;
    else if (sts_rd_en)
      sts_rd_data <= sts_d;
  end

endmodule : gcd_top

// ===== gcd_top_asserts.sv
// port checks for gcd_top
// assumes one mclk domain; bound into gcd_top
module gcd_top_asserts
(
  input logic                              mclk,
  input logic                              rstn,
  input logic                              cmd_wr_en,
  input logic [gcd_pkg::ADDR_W-1:0]        cmd_wr_addr,
  input logic [7:0]                        cmd_wr_data,
  input logic                              cmd_rd_en,
  input logic [gcd_pkg::ADDR_W-1:0]        cmd_rd_addr,
  input logic [7:0]                        cmd_rd_data,
  input logic [gcd_pkg::NUM_AXES-1:0][7:0] axis_pos,
  input logic [1:0]                        active_mode,
  input logic                              init_done,
  input logic                              fault_major
);
  timeunit 1ns;
  timeprecision 100ps;
  import gcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the command image
  logic [IMG_BYTES-1:0][7:0] img_q;
  logic [7:0]                exp_q;
  logic [7:0]                pt;
  logic [1:0]                mode_s;
  logic                      act_s;
  logic                      go_s;
  logic                      rel_s;
  logic                      ics_s;

  assign act_s  = img_q[IDX_ACTION][BIT_ACT];
  assign go_s   = img_q[IDX_ACTION][BIT_GO];
  assign rel_s  = img_q[IDX_ACTION][BIT_REL];
  assign mode_s = img_q[IDX_ACTION][BIT_MODE_HI:BIT_MODE_LO];
  assign ics_s  = img_q[IDX_OPTIONS][BIT_ICS];

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      img_q <= '0;
    else if (cmd_wr_en)
      img_q[cmd_wr_addr] <= cmd_wr_data;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      exp_q <= 8'h00;
    else if (cmd_rd_en)
      exp_q <= img_q[cmd_rd_addr];
  end

  always_comb
  begin
    case (active_mode)
      MODE_PINCH: pt = SCIS_POS_PINCH;
      MODE_WIDE:  pt = SCIS_POS_WIDE;
      MODE_SCISSOR: pt = SCIS_POS_SCISSOR;
      default:    pt = SCIS_POS_BASIC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // margin of four cycles covers the image-to-sequencer lag
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_reset_quiet: assert property (!act_s[*4] |-> !init_done && !fault_major && !active_mode)
    else $error("not cleared");
  a_idle_still: assert property (!act_s [*4] |=> $stable(axis_pos))
    else $error("moved inactive");
  a_go_hold: assert property (
      (init_done && act_s && !go_s && !rel_s && (ics_s || mode_s == active_mode)) [*4]
      |=> $stable(axis_pos[2:0]))
    else $error("moved without go");
  a_mode_open: assert property ($changed(active_mode) && active_mode != 2'h0 |->
      $past(axis_pos) == '0)
    else $error("mode before open");
  a_init_mode: assert property ($rose(init_done) && !ics_s |->
      active_mode == mode_s && axis_pos[3] == pt)
    else $error("bad ready mode");
  a_release_open: assert property ($rose(fault_major) |-> axis_pos == '0)
    else $error("fault before open");
  a_release_bound: assert property ($rose(rel_s) && act_s && init_done |->
      ##[1:400] fault_major)
    else $error("release hung");
  a_fault_still: assert property (fault_major |=> $stable(axis_pos))
    else $error("moved in fault");
  a_fault_keep: assert property (fault_major && act_s |=> fault_major)
    else $error("fault left");
  a_readback_val: assert property (cmd_rd_en ##1 !cmd_rd_en |=> cmd_rd_data == exp_q)
    else $error("readback");
  a_scis_range: assert property (
      ics_s && act_s && init_done && !rel_s && !fault_major &&
      axis_pos[3] inside {[SCIS_IND_MIN:SCIS_IND_MAX]} |=>
      axis_pos[3] inside {[SCIS_IND_MIN:SCIS_IND_MAX]})
    else $error("scissor range");

  c_ready: cover property ($rose(init_done));
  c_fault: cover property ($rose(fault_major));
  c_mode: cover property ($changed(active_mode) && active_mode != 2'h0);
  c_scis: cover property (ics_s && axis_pos[3] == SCIS_IND_MAX);
endmodule : gcd_top_asserts

bind gcd_top gcd_top_asserts u_chk (
  .mclk(mclk), .rstn(rstn), .cmd_wr_en(cmd_wr_en), .cmd_wr_addr(cmd_wr_addr),
  .cmd_wr_data(cmd_wr_data), .cmd_rd_en(cmd_rd_en), .cmd_rd_addr(cmd_rd_addr),
  .cmd_rd_data(cmd_rd_data), .axis_pos(axis_pos), .active_mode(active_mode),
  .init_done(init_done), .fault_major(fault_major)
);

// ===== gcd_ctl_model.sv
// controller model: writes and reads the shared image
// assumes strobes sampled on rising mclk
module gcd_ctl_model
(
  input  logic                       mclk,
  output logic                       wr_en,
  output logic [gcd_pkg::ADDR_W-1:0] wr_addr,
  output logic [7:0]                 wr_data,
  output logic                       rd_en,
  output logic                       sts_en,
  output logic [gcd_pkg::ADDR_W-1:0] rd_addr,
  input  logic [7:0]                 rd_data,
  input  logic [7:0]                 sts_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import gcd_pkg::*;

  // idle cycles after each write, for a slow controller
  int pace = 0;

  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    sts_en = 1'b0;
    wr_addr = '0;
    wr_data = 8'h00;
    rd_addr = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // released lines show the inverse so stale values never match
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
    repeat (pace) @(negedge mclk);
  endtask : wr

  task automatic rd(input logic s, input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge mclk);
    rd_en = !s;
    sts_en = s;
    rd_addr = a;
    @(negedge mclk);
    rd_en = 1'b0;
    sts_en = 1'b0;
    rd_addr = ~a;
    @(negedge mclk);
    d = s ? sts_data : rd_data;
  endtask : rd

  task automatic zero_all();
    for (int i = IMG_BYTES - 1; i >= 0; i--)
      wr(ADDR_W'(i), 8'h00);
  endtask : zero_all
endmodule : gcd_ctl_model

// ===== gcd_top_test.sv
// self-checking bench for gcd_top
// assumes gcd_ctl_model drives the bus; checker bound in
module gcd_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import gcd_pkg::*;

  logic                     mclk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     wr_en;
  logic                     rd_en;
  logic                     sts_en;
  logic [ADDR_W-1:0]        wr_addr;
  logic [ADDR_W-1:0]        rd_addr;
  logic [7:0]               wr_data;
  logic [7:0]               rd_data;
  logic [7:0]               sts_data;
  logic [NUM_AXES-1:0][7:0] axis_pos;
  logic [1:0]               active_mode;
  logic                     init_done;
  logic                     motion_busy;
  logic                     fault_major;
  logic [7:0]               v;
  int                       fails = 0;
  int                       tests_run = 0;
  logic [1:0] md [5] = '{MODE_BASIC, MODE_PINCH, MODE_WIDE, MODE_SCISSOR, MODE_BASIC};
  logic [7:0] sp [5] = '{SCIS_POS_BASIC, SCIS_POS_PINCH, SCIS_POS_WIDE, SCIS_POS_SCISSOR,
                         SCIS_POS_BASIC};

  always #5 mclk = ~mclk;

  gcd_top DUT (
    .mclk(mclk), .rstn(rstn), .cmd_wr_en(wr_en), .cmd_wr_addr(wr_addr),
    .cmd_wr_data(wr_data), .cmd_rd_en(rd_en), .cmd_rd_addr(rd_addr),
    .cmd_rd_data(rd_data), .sts_rd_en(sts_en), .sts_rd_addr(rd_addr),
    .sts_rd_data(sts_data), .axis_pos(axis_pos), .active_mode(active_mode),
    .init_done(init_done), .motion_busy(motion_busy), .fault_major(fault_major)
  );

  gcd_ctl_model ctl (
    .mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .sts_en(sts_en), .rd_addr(rd_addr), .rd_data(rd_data), .sts_data(sts_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  function automatic bit hit(int k, int i, logic [7:0] e);
    case (k)
      0: return axis_pos[i] === e;
      1: return init_done === 1'b1 && active_mode === md[i] && axis_pos[3] === sp[i];
      default: return fault_major === 1'b1;
    endcase
  endfunction : hit

  // bounded wait; timeout fails and ends the run
  task automatic wt(int k, int i, logic [7:0] e);
    int n = 0;
    tests_run++;
    while (!hit(k, i, e))
    begin
      @(negedge mclk);
      n++;
      if (n > 3000)
      begin
        fails++;
        $display("[ERR] %0t wait %0d timed out", $time, k);
        complete_run();
      end
    end
  endtask : wt

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    chk({4'h0, init_done, fault_major, active_mode}, 8'h00);
    // spare bits with activation clear
    ctl.wr(IDX_ACTION, 8'he0);
    ctl.wr(IDX_OPTIONS2, 8'ha5);
    ctl.wr(IDX_RSVD, 8'h5a);
    ctl.rd(0, IDX_ACTION, v);
    chk(v, 8'he0);
    ctl.rd(0, IDX_OPTIONS2, v);
    chk(v, 8'ha5);
    ctl.rd(0, IDX_RSVD, v);
    chk(v, 8'h5a);
    ctl.rd(1, SIDX_STATUS, v);
    chk(v, 8'h00);
    ctl.zero_all();
    // first pass activates, the rest change mode
    for (int i = 0; i < 5; i++)
    begin
      ctl.wr(IDX_ACTION, {5'h0, md[i], 1'b1});
      wt(1, i, 8'h00);
      chk(axis_pos[3], sp[i]);
      ctl.rd(1, SIDX_STATUS, v);
      chk(v, {2'b00, INIT_DONE, 1'b0, md[i], 1'b1});
    end
    ctl.wr(IDX_POS_A, 8'h40);
    ctl.wr(IDX_SPD_A, 8'hc0);
    repeat (20) @(negedge mclk);
    chk(axis_pos[0], 8'h00);
    ctl.wr(IDX_ACTION, 8'h09);
    @(negedge mclk);
    chk({7'h0, motion_busy}, 8'h01);
    for (int i = 0; i < 3; i++)
      wt(0, i, 8'h40);
    ctl.rd(1, SIDX_ECHO_A, v);
    chk(v, 8'h40);
    ctl.wr(IDX_POS_B, 8'h20);
    ctl.wr(IDX_SPD_B, 8'hc0);
    ctl.wr(IDX_POS_C, 8'h60);
    ctl.wr(IDX_SPD_C, 8'hc0);
    ctl.wr(IDX_OPTIONS, 8'h04);
    wt(0, 1, 8'h20);
    wt(0, 2, 8'h60);
    chk(axis_pos[0], 8'h40);
    ctl.wr(IDX_POS_B, 8'h30);
    ctl.wr(IDX_POS_C, 8'h30);
    ctl.wr(IDX_OPTIONS, 8'h06);
    wt(0, 2, 8'h30);
    chk(axis_pos[1], 8'h30);
    ctl.wr(IDX_POS_A, 8'hc0);
    ctl.wr(IDX_ACTION, 8'h01);
    repeat (3) @(negedge mclk);
    v = axis_pos[0];
    repeat (20) @(negedge mclk);
    chk(axis_pos[0], v);
    ctl.pace = 2;
    ctl.wr(IDX_POS_S, 8'hf8);
    ctl.wr(IDX_SPD_S, 8'hc0);
    ctl.wr(IDX_OPTIONS, 8'h08);
    ctl.wr(IDX_ACTION, 8'h0f);
    wt(0, 3, SCIS_IND_MAX);
    chk(8'(active_mode), 8'(MODE_BASIC));
    ctl.wr(IDX_POS_S, 8'h05);
    wt(0, 3, SCIS_IND_MIN);
    // release together with a pending mode change
    ctl.wr(IDX_ACTION, 8'h1d);
    ctl.wr(IDX_OPTIONS, 8'h00);
    wt(2, 0, 8'h00);
    for (int i = 0; i < 4; i++)
      chk(axis_pos[i], 8'h00);
    chk(8'(active_mode), 8'(MODE_BASIC));
    ctl.rd(1, SIDX_FAULT, v);
    chk(v, FAULT_RELEASE);
    ctl.wr(IDX_ACTION, 8'h09);
    repeat (20) @(negedge mclk);
    chk(axis_pos[0], 8'h00);
    chk(8'(fault_major), 8'h01);
    ctl.wr(IDX_ACTION, 8'h00);
    ctl.rd(1, SIDX_FAULT, v);
    chk(v, FAULT_NONE);
    ctl.wr(IDX_ACTION, 8'h01);
    wt(1, 0, 8'h00);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    chk(axis_pos[3], 8'h00);
    complete_run();
  end
endmodule : gcd_top_test
